// ### rtl/rtcd_decoder.sv
`timescale 1ns/10ps
// Summary of operation
// RULE1: line increment field is received but discarded
// RULE2: sequence bit inverts 625-line colour difference only
// RULE3: reset bit resets phase when fully enabled
// RULE4: received field rate overrides local setting
// RULE5: field rate bit: 0 50 Hz, 1 60 Hz
// RULE6: received odd/even replaces internal flag when enabled
// RULE7: colour-detect bit picks internal or received subcarrier
// RULE8: without colour-detect use, received subcarrier always used
// RULE9: two spare slots follow the line increment
// RULE10: five spare slots follow the subcarrier increment
// RULE11: skip 229 or 226 trailing slots
// RULE12: master enable off keeps every internal value
module rtcd_decoder
  import rtcd_pkg::*;
(
  // clock, reset, enable
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // avalon-mm slave
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // serial control word pin
  input wire logic realtime_control_word_input_i,
  // internal generation
  input wire logic internal_odd_even_i,
  input wire logic internal_colour_seq_i,
  // decoded results
  output logic [RTCD_INC_W-1:0] subcarrier_increment_o,
  output logic subcarrier_from_word_o,
  output logic phase_reset_o,
  output logic field_rate_o,
  output logic odd_even_o,
  output logic colour_seq_o,
  output logic word_valid_o
);
  // =============================================================
  // byte-lane merge used by every writable register
  function automatic logic [31:0] rtcd_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] be);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : rtcd_merge
  // =============================================================
  // pin synchroniser
  logic pin_lvl;  // filtered pin level
  logic pin_lvl_d_ff;  // previous filtered level
  logic nxt_pin_lvl_d;
  rtcd_sync u_sync (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .pin_i(realtime_control_word_input_i),
    .level_o(pin_lvl)
  );
  // =============================================================
  // register file
  rtcd_ctrl_t ctrl_ff;  // control register
  rtcd_ctrl_t nxt_ctrl;
  logic [RTCD_INC_W-1:0] incr_ff;  // internal subcarrier increment
  logic [RTCD_INC_W-1:0] nxt_incr;
  logic ack_ff;  // one wait state then accept
  logic nxt_ack;
  logic [31:0] rdata_ff;  // registered read data
  logic [31:0] nxt_rdata;
  logic [31:0] merged;  // merged write value
  rtcd_word_t word_ff;  // last received word
  logic [31:0] status_v;  // status view
  // bus next values
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_incr = incr_ff;
    nxt_ack = ce_i ? 1'b0 : ack_ff;
    nxt_rdata = rdata_ff;
    merged = 32'h00000000;
    status_v = {8'h00, word_ff.sub_inc[RTCD_INC_W-1:RTCD_INC_W-19], word_ff.colour_seq,
                word_ff.phase_reset, word_ff.field_rate, word_ff.odd_even, word_ff.colour_det};
    if (ce_i && (avs_read_i || avs_write_i) && !ack_ff) begin
      nxt_ack = 1'b1;
      unique case (avs_address_i)
        // control register
        RTCD_ADDR_CTRL: begin
          merged = rtcd_merge({24'h000000, ctrl_ff}, avs_writedata_i, avs_byteenable_i);
          nxt_rdata = {24'h000000, ctrl_ff};
          if (avs_write_i) begin
            nxt_ctrl = merged[RTCD_CTRL_W-1:0];
          end
        end
        // status of last word
        RTCD_ADDR_STATUS: begin
          nxt_rdata = status_v;
        end
        // internal increment
        RTCD_ADDR_INCR: begin
          merged = rtcd_merge({10'h000, incr_ff}, avs_writedata_i, avs_byteenable_i);
          nxt_rdata = {10'h000, incr_ff};
          if (avs_write_i) begin
            nxt_incr = merged[RTCD_INC_W-1:0];
          end
        end
        // unmapped: reads zero, writes dropped
        default: begin
          nxt_rdata = 32'h00000000;
        end
      endcase
    end
  end
  // bus registers
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_ff <= RTCD_CTRL_RESET;
      incr_ff <= RTCD_INCR_RESET;
      ack_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
    end else begin
      ctrl_ff <= nxt_ctrl;
      incr_ff <= nxt_incr;
      ack_ff <= nxt_ack;
      rdata_ff <= nxt_rdata;
    end
  end
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_ff;
  assign avs_readdata_o = rdata_ff;
  // =============================================================
  // serial deserialiser
  rtcd_state_t state_ff;  // decoder state
  rtcd_state_t nxt_state;
  logic [7:0] slot_ff;  // slot within the current field
  logic [7:0] nxt_slot;
  logic [RTCD_INC_W-1:0] sub_sr_ff;  // subcarrier shift register
  logic [RTCD_INC_W-1:0] nxt_sub_sr;
  logic [4:0] flag_sr_ff;  // flag shift register
  logic [4:0] nxt_flag_sr;
  logic [7:0] tail_len;  // trailing spare length of this word
  rtcd_word_t nxt_word;
  logic done_ff;  // word complete pulse
  logic nxt_done;
  logic half_ff;  // set on the first clock of a bit slot
  logic nxt_half;
  // decoder next values
  always_comb begin
    nxt_state = state_ff;
    nxt_slot = slot_ff;
    nxt_sub_sr = sub_sr_ff;
    nxt_flag_sr = flag_sr_ff;
    nxt_word = word_ff;
    nxt_done = ce_i ? 1'b0 : done_ff;
    nxt_pin_lvl_d = ce_i ? pin_lvl : pin_lvl_d_ff;
    nxt_half = ce_i ? ~half_ff : half_ff;
    tail_len = (word_ff.field_rate == RTCD_RATE_60) ? RTCD_TAIL_60 : RTCD_TAIL_50;  // RULE11
    // a slot lasts two clocks so the pin filter passes it; taken on its first clock
    if (ce_i && (half_ff || (state_ff == RTCD_S_IDLE))) begin
      nxt_slot = slot_ff + RTCD_SLOT_ONE;
      unique case (state_ff)
        // wait for the rising start bit
        RTCD_S_IDLE: begin
          nxt_slot = 8'h00;
          if (pin_lvl && !pin_lvl_d_ff) begin
            nxt_half = 1'b0;
            nxt_state = RTCD_S_LINE;
          end
        end
        // line increment and its spare slots, content dropped
        RTCD_S_LINE: begin
          if (slot_ff == RTCD_LINE_SLOTS - RTCD_SLOT_ONE) begin  // RULE1 RULE9
            nxt_slot = 8'h00;
            nxt_state = RTCD_S_SUB;
          end
        end
        // subcarrier increment msb first, then spare slots
        RTCD_S_SUB: begin
          if (slot_ff < RTCD_SUB_BITS) begin
            nxt_sub_sr = {sub_sr_ff[RTCD_INC_W-2:0], pin_lvl};
          end
          if (slot_ff == RTCD_SUB_SLOTS - RTCD_SLOT_ONE) begin  // RULE10
            nxt_slot = 8'h00;
            nxt_state = RTCD_S_FLAGS;
          end
        end
        // five flag bits, word latched on the last
        RTCD_S_FLAGS: begin
          nxt_flag_sr = {flag_sr_ff[3:0], pin_lvl};
          if (slot_ff == RTCD_FLAG_SLOTS - RTCD_SLOT_ONE) begin
            nxt_word = {sub_sr_ff, flag_sr_ff[3:0], pin_lvl};
            nxt_done = 1'b1;
            nxt_slot = 8'h00;
            nxt_state = RTCD_S_TAIL;
          end
        end
        // trailing spare slots, pin ignored
        RTCD_S_TAIL: begin
          if (slot_ff == tail_len - RTCD_SLOT_ONE) begin  // RULE11
            nxt_slot = 8'h00;
            nxt_state = RTCD_S_IDLE;
          end
        end
        default: begin
          nxt_slot = 8'h00;
          nxt_state = RTCD_S_IDLE;
        end
      endcase
    end
  end
  // decoder registers
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= RTCD_S_IDLE;
      slot_ff <= 8'h00;
      sub_sr_ff <= 22'h000000;
      flag_sr_ff <= 5'h00;
      word_ff <= '0;
      done_ff <= 1'b0;
      pin_lvl_d_ff <= 1'b0;
      half_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      slot_ff <= nxt_slot;
      sub_sr_ff <= nxt_sub_sr;
      flag_sr_ff <= nxt_flag_sr;
      word_ff <= nxt_word;
      done_ff <= nxt_done;
      pin_lvl_d_ff <= nxt_pin_lvl_d;
      half_ff <= nxt_half;
    end
  end
  // =============================================================
  // value selection and registered outputs
  logic [RTCD_INC_W-1:0] sel_inc;
  logic sel_from_word;
  logic sel_rate;
  logic sel_oe;
  logic sel_seq;
  logic [RTCD_INC_W-1:0] inc_ff;
  logic from_word_ff;
  logic rate_ff;
  logic oe_ff;
  logic seq_ff;
  logic phase_reset_select_ff;
  logic nxt_phase_reset_select;
  rtcd_select u_select (
    .ctrl_i(ctrl_ff),
    .word_i(word_ff),
    .int_inc_i(incr_ff),
    .int_odd_even_i(internal_odd_even_i),
    .int_colour_seq_i(internal_colour_seq_i),
    .sub_inc_o(sel_inc),
    .sub_from_word_o(sel_from_word),
    .field_rate_o(sel_rate),
    .odd_even_o(sel_oe),
    .colour_seq_o(sel_seq)
  );
  // phase reset pulse on a completed word
  always_comb begin
    nxt_phase_reset_select = ce_i ? 1'b0 : phase_reset_select_ff;
    if (ce_i && done_ff && ctrl_ff.control_input_enable && ctrl_ff.phase_reset_decode_enable &&
        (ctrl_ff.phase_reset_select == RTCD_PHSEL_LINE) && word_ff.phase_reset) begin
      nxt_phase_reset_select = 1'b1;  // RULE3
    end
  end
  // output registers
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      inc_ff <= 22'h000000;
      from_word_ff <= 1'b0;
      rate_ff <= RTCD_RATE_50;
      oe_ff <= 1'b0;
      seq_ff <= 1'b0;
      phase_reset_select_ff <= 1'b0;
    end else begin
      phase_reset_select_ff <= nxt_phase_reset_select;
      if (ce_i) begin
        inc_ff <= sel_inc;
        from_word_ff <= sel_from_word;
        rate_ff <= sel_rate;
        oe_ff <= sel_oe;
        seq_ff <= sel_seq;
      end
    end
  end
  assign subcarrier_increment_o = inc_ff;
  assign subcarrier_from_word_o = from_word_ff;
  assign field_rate_o = rate_ff;
  assign odd_even_o = oe_ff;
  assign colour_seq_o = seq_ff;
  assign phase_reset_o = phase_reset_select_ff;
  assign word_valid_o = done_ff;
  // =============================================================
  // checks
  AST_PHASE_RESET: assert property (@(posedge clock_i) disable iff (rst_i) // RULE3
    (ce_i && done_ff && ctrl_ff.control_input_enable && ctrl_ff.phase_reset_decode_enable &&
     ctrl_ff.phase_reset_select == RTCD_PHSEL_LINE && word_ff.phase_reset) |=> phase_reset_o)
    else $error("phase reset missing");
  AST_PHASE_NEEDS_ENABLE: assert property (@(posedge clock_i) disable iff (rst_i) // RULE12
    phase_reset_o |-> $past(ctrl_ff.control_input_enable) && $past(done_ff))
    else $error("phase reset without enable");
  AST_FIELD_RATE_WORD: assert property (@(posedge clock_i) disable iff (rst_i) // RULE4
    (ce_i && ctrl_ff.control_input_enable && ctrl_ff.field_rate_from_input)
    |=> field_rate_o == $past(word_ff.field_rate))
    else $error("field rate not from word");
  AST_FIELD_RATE_LOCAL: assert property (@(posedge clock_i) disable iff (rst_i) // RULE12
    (ce_i && !ctrl_ff.control_input_enable) |=> field_rate_o == $past(ctrl_ff.field_rate_select))
    else $error("field rate not local");
  AST_ODD_EVEN: assert property (@(posedge clock_i) disable iff (rst_i) // RULE6
    (ce_i && ctrl_ff.control_input_enable && ctrl_ff.odd_even_from_input)
    |=> odd_even_o == $past(word_ff.odd_even))
    else $error("odd even not from word");
  AST_COLOUR_INTERNAL: assert property (@(posedge clock_i) disable iff (rst_i) // RULE7
    (ce_i && ctrl_ff.control_input_enable && ctrl_ff.colour_detect_use && !word_ff.colour_det)
    |=> subcarrier_increment_o == $past(incr_ff) && !subcarrier_from_word_o)
    else $error("internal subcarrier not used");
  AST_COLOUR_ALWAYS_WORD: assert property (@(posedge clock_i) disable iff (rst_i) // RULE8
    (ce_i && ctrl_ff.control_input_enable && !ctrl_ff.colour_detect_use)
    |=> subcarrier_increment_o == $past(word_ff.sub_inc))
    else $error("received subcarrier not used");
  AST_SEQ_525: assert property (@(posedge clock_i) disable iff (rst_i) // RULE2
    (ce_i && ctrl_ff.control_input_enable && sel_rate == RTCD_RATE_60) |=> !colour_seq_o)
    else $error("sequence bit in 525-line mode");
  AST_TAIL_LEN: assert property (@(posedge clock_i) disable iff (rst_i) // RULE11
    (ce_i && state_ff == RTCD_S_TAIL && nxt_state == RTCD_S_IDLE)
    |-> slot_ff == ((word_ff.field_rate == RTCD_RATE_60) ? RTCD_TAIL_60 : RTCD_TAIL_50) - 8'h01)
    else $error("tail length wrong");
  AST_FLAGS_AFTER_SUB: assert property (@(posedge clock_i) disable iff (rst_i) // RULE10
    (ce_i && state_ff == RTCD_S_SUB && nxt_state == RTCD_S_FLAGS) |-> slot_ff == 8'h1A)
    else $error("subcarrier field length wrong");
  AST_BUS_WAIT: assert property (@(posedge clock_i) disable iff (rst_i)
    (ce_i && avs_read_i && avs_waitrequest_o) |=> !avs_waitrequest_o)
    else $error("bus wait longer than one cycle");
endmodule : rtcd_decoder

// ### rtl/rtcd_pkg.sv
// =============================================================
// shared constants and types of the control word decoder
package rtcd_pkg;
  // =============================================================
  // serial word layout, counted in bit slots after the start bit
  localparam logic [7:0] RTCD_LINE_SLOTS = 8'h11;  // 15 line bits plus 2 spare slots
  localparam logic [7:0] RTCD_SUB_BITS = 8'h16;  // subcarrier increment bits 21..0
  localparam logic [7:0] RTCD_SUB_SLOTS = 8'h1B;  // 22 bits plus 5 spare slots
  localparam logic [7:0] RTCD_FLAG_SLOTS = 8'h05;  // seq, reset, rate, odd/even, colour
  localparam logic [7:0] RTCD_TAIL_50 = 8'hE5;  // trailing spare slots, 50 Hz
  localparam logic [7:0] RTCD_TAIL_60 = 8'hE2;  // trailing spare slots, 60 Hz
  localparam int RTCD_INC_W = 22;  // subcarrier increment width
  localparam logic [7:0] RTCD_SLOT_ONE = 8'h01;  // counter step
  localparam logic RTCD_RATE_50 = 1'b0;  // field-rate code for 50 Hz
  localparam logic RTCD_RATE_60 = 1'b1;  // field-rate code for 60 Hz
  localparam logic [1:0] RTCD_PHSEL_LINE = 2'h0;  // phase reset taken from the word
  // =============================================================
  // register map (byte addresses) and control field positions
  localparam logic [3:0] RTCD_ADDR_CTRL = 4'h0;
  localparam logic [3:0] RTCD_ADDR_STATUS = 4'h4;
  localparam logic [3:0] RTCD_ADDR_INCR = 4'h8;
  localparam int RTCD_CTRL_W = 8;
  localparam logic [7:0] RTCD_CTRL_RESET = 8'h00;
  localparam logic [21:0] RTCD_INCR_RESET = 22'h000000;
  // =============================================================
  // control register, bit 7 down to bit 0
  typedef struct packed {
    logic field_rate_select;  // local field rate setting
    logic colour_detect_use;  // honour colour-detect bit
    logic odd_even_from_input;  // follow received odd/even
    logic field_rate_from_input;  // follow received field rate
    logic [1:0] phase_reset_select;  // phase reset source
    logic phase_reset_decode_enable;  // decode received reset bit
    logic control_input_enable;  // master enable of the word
  } rtcd_ctrl_t;
  // fields of one received word
  typedef struct packed {
    logic [RTCD_INC_W-1:0] sub_inc;  // subcarrier pll increment
    logic colour_seq;  // inverted colour-difference line
    logic phase_reset;  // phase reset request
    logic field_rate;  // 0 = 50 Hz, 1 = 60 Hz
    logic odd_even;  // field parity
    logic colour_det;  // colour present at source
  } rtcd_word_t;
  // decoder states
  typedef enum logic [2:0] {
    RTCD_S_IDLE = 3'b000,
    RTCD_S_LINE = 3'b001,
    RTCD_S_SUB = 3'b010,
    RTCD_S_FLAGS = 3'b011,
    RTCD_S_TAIL = 3'b100
  } rtcd_state_t;
endpackage : rtcd_pkg

// ### rtl/rtcd_sync.sv
`timescale 1ns/10ps
// =============================================================
// three-stage pin synchroniser with agreement filter
module rtcd_sync
  import rtcd_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // pin and filtered level
  input wire logic pin_i,
  output logic level_o
);
  logic [2:0] stage_ff;  // stage 0 is read only by stage 1
  logic [2:0] nxt_stage;
  logic level_ff;  // filtered level
  logic nxt_level;
  // next values: shift and accept a level once two stages agree
  always_comb begin
    nxt_stage = stage_ff;
    nxt_level = level_ff;
    if (ce_i) begin
      nxt_stage = {stage_ff[1:0], pin_i};
      if (stage_ff[1] == stage_ff[2]) begin
        nxt_level = stage_ff[2];
      end
    end
  end
  // registers
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      stage_ff <= 3'h0;
      level_ff <= 1'b0;
    end else begin
      stage_ff <= nxt_stage;
      level_ff <= nxt_level;
    end
  end
  assign level_o = level_ff;
endmodule : rtcd_sync

// ### rtl/rtcd_select.sv
`timescale 1ns/10ps
// =============================================================
// chooses received or internal values per enable bit
module rtcd_select
  import rtcd_pkg::*;
(
  // settings and received word
  input wire rtcd_ctrl_t ctrl_i,
  input wire rtcd_word_t word_i,
  // internal generation
  input wire logic [RTCD_INC_W-1:0] int_inc_i,
  input wire logic int_odd_even_i,
  input wire logic int_colour_seq_i,
  // chosen values
  output logic [RTCD_INC_W-1:0] sub_inc_o,
  output logic sub_from_word_o,
  output logic field_rate_o,
  output logic odd_even_o,
  output logic colour_seq_o
);
  logic en;  // master enable
  // selection, internal values whenever the master enable is off
  always_comb begin
    en = ctrl_i.control_input_enable;  // RULE12
    sub_from_word_o = en & (~ctrl_i.colour_detect_use | word_i.colour_det);  // RULE7 RULE8
    sub_inc_o = sub_from_word_o ? word_i.sub_inc : int_inc_i;
    field_rate_o = ctrl_i.field_rate_select;
    if (en & ctrl_i.field_rate_from_input) begin
      field_rate_o = word_i.field_rate;  // RULE4 RULE5
    end
    odd_even_o = (en & ctrl_i.odd_even_from_input) ? word_i.odd_even : int_odd_even_i;  // RULE6
    // 525-line operation carries no inversion
    colour_seq_o = int_colour_seq_i;
    if (en) begin
      colour_seq_o = (field_rate_o == RTCD_RATE_50) ? word_i.colour_seq : 1'b0;  // RULE2
    end
  end
endmodule : rtcd_select

// ### sim/rtcd_src_model.sv
`timescale 1ns/10ps
// =====
// upstream source model: sends one control word per request
module rtcd_src_model
  import rtcd_pkg::*;
(
  // clock and request
  input wire logic clock_i,
  input wire logic send_i,
  input wire rtcd_word_t word_i,
  input wire logic [31:0] noise_i,
  // serial pin and state
  output logic pin_o,
  output logic busy_o
);
  rtcd_word_t w;  // word being sent
  int i;  // slot index
  int tail;  // trailing spare slots
  // end the current slot after two clocks, then drive the next one
  task automatic slot(input logic b);
    repeat (2) @(posedge clock_i);
    pin_o <= b;
  endtask : slot
  // idle line is low; a high start slot opens each word
  initial begin
    pin_o = 1'b0;
    busy_o = 1'b0;
    forever begin
      @(posedge clock_i);
      if (send_i === 1'b1) begin
        w = word_i;
        busy_o <= 1'b1;
        pin_o <= 1'b1;
        // line increment slots carry junk the decoder must not use
        for (i = 0; i < 17; i++) slot(noise_i[0]);
        // subcarrier increment, msb first
        for (i = RTCD_INC_W - 1; i >= 0; i--) slot(w.sub_inc[i]);
        // spare slots before the flags
        for (i = 0; i < 5; i++) slot(noise_i[0]);
        slot(w.colour_seq);
        slot(w.phase_reset);
        slot(w.field_rate);
        slot(w.odd_even);
        slot(w.colour_det);
        // trailing spare slots, junk except a low run at the end
        tail = (w.field_rate == RTCD_RATE_50) ? int'(RTCD_TAIL_50) : int'(RTCD_TAIL_60);
        for (i = 0; i < tail; i++) slot((i < tail - 4) ? noise_i[0] : 1'b0);
        // guard gap before the next start
        repeat (6) slot(1'b0);
        busy_o <= 1'b0;
      end
    end
  end
endmodule : rtcd_src_model

// ### sim/tb.sv
`timescale 1ns/10ps
// =====
// self-checking bench of the control word decoder
module tb
  import rtcd_pkg::*;
;
  logic clock_i, rst_i, ce_i;  // clock, reset, enable
  logic [3:0] avs_address_i;  // bus address
  logic avs_read_i, avs_write_i;  // bus strobes
  logic [31:0] avs_writedata_i, avs_readdata_o;  // bus data
  logic [3:0] avs_byteenable_i;  // lanes
  logic avs_waitrequest_o;  // wait flag
  logic pin, int_oe, int_seq;  // pin and internal levels
  logic [RTCD_INC_W-1:0] sub_inc;  // chosen increment
  logic from_word, phase_reset, field_rate, odd_even, colour_seq, word_valid;
  logic send, src_busy;  // source handshake
  rtcd_word_t word;  // word to send
  logic [31:0] seed, noise;  // random state
  int bad_count, cmp_count, wv_count, pr_count;
  // =====
  // design and source
  rtcd_decoder u_rtcd_decoder (.clock_i(clock_i), .rst_i(rst_i), .ce_i(ce_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .realtime_control_word_input_i(pin), .internal_odd_even_i(int_oe),
    .internal_colour_seq_i(int_seq), .subcarrier_increment_o(sub_inc),
    .subcarrier_from_word_o(from_word), .phase_reset_o(phase_reset),
    .field_rate_o(field_rate), .odd_even_o(odd_even), .colour_seq_o(colour_seq),
    .word_valid_o(word_valid));
  rtcd_src_model u_rtcd_src_model (.clock_i(clock_i), .send_i(send), .word_i(word),
    .noise_i(noise), .pin_o(pin), .busy_o(src_busy));
  // =====
  // helpers
  function automatic logic [31:0] step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : step
  // compare one result
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  // one avalon transfer, held until waitrequest is low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clock_i);
    avs_address_i <= a;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    avs_writedata_i <= d;
    do begin
      @(posedge clock_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 40);
    if (n >= 40) chk("waitrequest", 32'h0, 32'h1);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask : bus
  // one word: program, send, compare with the model
  task automatic run_word(input logic [7:0] c);
    rtcd_ctrl_t ct;
    rtcd_word_t w;
    logic [21:0] inc;
    logic [31:0] q;
    logic en, fw, rate;
    int pr0, n;
    ct = c;
    en = ct.control_input_enable;
    seed = step(seed);
    inc = seed[21:0];
    seed = step(seed);
    w = seed[26:0];
    if (w.field_rate == RTCD_RATE_60) w.colour_seq = 1'b0;
    bus(1'b1, RTCD_ADDR_CTRL, {24'h0, c}, q);
    bus(1'b1, RTCD_ADDR_INCR, {10'h0, inc}, q);
    @(posedge clock_i);
    int_oe <= seed[30];
    int_seq <= seed[31];
    word <= w;
    send <= 1'b1;
    @(posedge clock_i);
    send <= 1'b0;
    pr0 = pr_count;
    n = 0;
    do begin
      @(posedge clock_i);
      #1;
      n++;
    end while (word_valid !== 1'b1 && n < 200);
    if (n >= 200) chk("word wait", 32'h0, 32'h1);
    repeat (3) @(posedge clock_i);
    #1;
    // reference model of the selection
    fw = en & (ct.colour_detect_use ? w.colour_det : 1'b1);
    rate = (en & ct.field_rate_from_input) ? w.field_rate : ct.field_rate_select;
    chk("from_word", 32'(fw), 32'(from_word));
    chk("increment", 32'(fw ? w.sub_inc : inc), 32'(sub_inc));
    chk("field_rate", 32'(rate), 32'(field_rate));
    chk("odd_even", 32'((en & ct.odd_even_from_input) ? w.odd_even : int_oe),
        32'(odd_even));
    chk("colour_seq", 32'(!en ? int_seq : (rate ? 1'b0 : w.colour_seq)),
        32'(colour_seq));
    chk("phase_reset", 32'(en & ct.phase_reset_decode_enable & w.phase_reset &
        (ct.phase_reset_select == RTCD_PHSEL_LINE)), 32'(pr_count - pr0));
    bus(1'b0, RTCD_ADDR_STATUS, 32'h0, q);
    chk("status", {8'h0, w.sub_inc[21:3], w.colour_seq, w.phase_reset, w.field_rate,
        w.odd_even, w.colour_det}, q);
    n = 0;
    while (src_busy === 1'b1 && n < 1000) begin
      @(posedge clock_i);
      n++;
    end
    if (n >= 1000) chk("source idle", 32'h0, 32'h1);
  endtask : run_word
  // print counts and verdict, then stop
  task automatic close_out();
    $display("compared %0d failed %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out
  // =====
  // clock, counters, watchdog
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end
  // pulse counters and junk source for the model
  always @(posedge clock_i) begin
    noise <= step(noise);
    if (word_valid === 1'b1) wv_count++;
    if (phase_reset === 1'b1) pr_count++;
  end
  // cut a hang short
  initial begin
    repeat (40000) @(posedge clock_i);
    $display("watchdog expired");
    bad_count++;
    close_out();
  end
  // =====
  // main sequence
  initial begin
    logic [31:0] q;
    logic [7:0] c;
    {avs_address_i, avs_read_i, avs_write_i, avs_writedata_i} = '0;
    {int_oe, int_seq, send, word} = '0;
    {bad_count, cmp_count, wv_count, pr_count} = '0;
    seed = 32'h32D3;
    noise = 32'h32D3;
    avs_byteenable_i = 4'hF;
    ce_i = 1'b1;
    rst_i = 1'b1;
    repeat (8) @(posedge clock_i);
    rst_i <= 1'b0;
    // reset values, read-only and unmapped places
    bus(1'b0, RTCD_ADDR_CTRL, 32'h0, q);
    chk("ctrl reset", 32'(RTCD_CTRL_RESET), q);
    bus(1'b0, RTCD_ADDR_INCR, 32'h0, q);
    chk("incr reset", 32'(RTCD_INCR_RESET), q);
    bus(1'b1, RTCD_ADDR_STATUS, 32'hFFFFFFFF, q);
    bus(1'b0, RTCD_ADDR_STATUS, 32'h0, q);
    chk("status ro", 32'h0, q);
    bus(1'b1, 4'hC, 32'hFFFFFFFF, q);
    bus(1'b0, 4'hC, 32'h0, q);
    chk("unmapped", 32'h0, q);
    bus(1'b1, RTCD_ADDR_INCR, 32'hFFFFFFFF, q);
    bus(1'b0, RTCD_ADDR_INCR, 32'h0, q);
    chk("incr width", 32'h003FFFFF, q);
    $display("test registers done");
    // words under varied settings, disabled first
    for (int i = 0; i < 24; i++) begin
      seed = step(seed);
      c = seed[7:0];
      if (i % 2 == 1) c[3:2] = RTCD_PHSEL_LINE;
      c[0] = (i % 4 != 0);
      run_word(c);
    end
    chk("word count", 32'd24, 32'(wv_count));
    $display("test words done");
    close_out();
  end
endmodule : tb
